//--- core/csfr_core.sv
// Purpose: core special registers: operands, stack top, dual pointers, status
// Assumes: one operation per cycle from the sequencer; memory reached outside
// Notes:   a special register write in the same cycle as an operation wins
//          for the register it addresses
module csfr_core
  import csfr_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,       // core clock
  input  wire logic        i_nrst,          // asynchronous reset, active low
  // special register port
  input  wire logic [7:0]  i_sfr_addr,      // register address
  input  wire logic        i_sfr_wr,        // write strobe
  input  wire logic        i_sfr_rd,        // read strobe
  input  wire logic [7:0]  i_sfr_wdata,     // write data
  output logic      [7:0]  o_sfr_rdata,     // read data, one cycle after strobe
  output logic             o_sfr_hit,       // read hit a register here
  // operation port
  input  wire logic        i_op_valid,      // operation this cycle
  input  csfr_op_e         i_op_code,       // which operation
  input  wire logic [7:0]  i_op_operand,    // byte operand or push data
  input  wire logic        i_op_bit,        // bit operand for carry logic
  input  wire logic [15:0] i_op_pc,         // return address for calls
  // stack memory requests
  output logic             o_stk_we,        // write request
  output logic             o_stk_re,        // read request
  output logic             o_stk_two,       // two-byte transfer
  output logic      [7:0]  o_stk_addr,      // first byte address
  output logic      [15:0] o_stk_wdata,     // write data, low byte first
  // pointer and bank views
  output logic      [15:0] o_data_pointer_pair,          // active data pointer
  output logic      [15:0] o_code_idx_addr, // pointer plus primary operand
  output logic      [7:0]  o_bank_base,     // first address of working bank
  output logic      [2:0]  o_aux_ctrl,      // auxiliary bits 3..1 to neighbours
  // program memory map
  input  wire logic [15:0] i_fetch_addr,    // program fetch address
  input  wire logic [15:0] i_iap_addr,      // in-application write address
  output csfr_region_e     o_fetch_region,  // partition of fetch address
  output logic             o_iap_free,      // write needs no protection bit
  // configuration word
  input  wire logic [15:0] i_cfg_word,      // flash bytes at 3FFEh..3FFFh
  output logic      [15:0] o_cfg_word,      // captured configuration
  output logic             o_cfg_loaded     // capture done
);

  // register state
  logic [7:0]  acc_r, acc_nxt;             // primary operand
  logic [7:0]  sec_r, sec_nxt;             // second operand
  logic [7:0]  sp_r, sp_nxt;               // stack top pointer
  logic [7:0]  psw_r, psw_nxt;             // status word, bit 0 unused here
  logic        par_r;                      // parity flag
  logic [3:0]  aux_r;                      // auxiliary control bits
  logic [15:0] data_pointer_pair_r [2];                 // two physical pointers
  logic [15:0] cfg_r;                      // configuration copy
  logic        cfg_done_r;                 // copy taken
  logic [7:0]  rdata_r;                    // registered read data
  logic        hit_r;                      // registered read hit
  logic        stk_we_r, stk_re_r, stk_two_r;
  logic [7:0]  stk_addr_r;
  logic [15:0] stk_wdata_r;

  // partition decode, shared by fetch and write paths
  function automatic csfr_region_e region_of(input logic [15:0] a);
    csfr_region_e rg;
    if (a > PM_TOP)                  rg = RG_OUTSIDE;
    else if (a <= PM_VEC_END)        rg = RG_VECTOR;
    else if (a >= PM_CFG_START)      rg = RG_CONFIG;
    else if (a >= PM_FREE_START)     rg = RG_IAP_FREE;
    else if (a >= PM_ICE_START && a <= PM_ICE_END)
                                     rg = RG_ICE_RESERVE;
    else                             rg = RG_USER;
    return rg;
  endfunction : region_of

  // address decode
  wire        sel_ptr  = aux_r[AUX_PTR_SEL];
  wire        wr_acc   = i_sfr_wr && (i_sfr_addr == SFR_PRIMARY);
  wire        wr_sec   = i_sfr_wr && (i_sfr_addr == SFR_SECOND);
  wire        wr_sp    = i_sfr_wr && (i_sfr_addr == SFR_STACK_TOP);
  wire        wr_psw   = i_sfr_wr && (i_sfr_addr == SFR_STATUS);
  wire        wr_aux   = i_sfr_wr && (i_sfr_addr == SFR_AUX_CTRL);
  wire        wr_dpl   = i_sfr_wr && (i_sfr_addr == SFR_DATA_POINTER_PAIR_LOW);
  wire        wr_dph   = i_sfr_wr && (i_sfr_addr == SFR_DATA_POINTER_PAIR_HIGH);
  wire        op_on    = i_op_valid && (i_op_code != OP_NONE);
  wire [15:0] data_pointer_pair_act = data_pointer_pair_r[sel_ptr];

  // flag inputs
  wire       cy     = psw_r[ST_CARRY];
  wire       ac     = psw_r[ST_HALF];
  wire       cin    = (i_op_code == OP_ADDC) ? cy : 1'b0;
  wire [7:0] opnd   = i_op_operand;

  // add and add-with-carry
  wire [8:0] add_sum = {1'b0, acc_r} + {1'b0, opnd} + {8'h00, cin};
  wire [4:0] add_lo  = {1'b0, acc_r[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
  wire       add_ov  = (acc_r[7] == opnd[7]) && (add_sum[7] != acc_r[7]);

  // subtract with borrow
  wire [8:0] sub_dif = {1'b0, acc_r} - {1'b0, opnd} - {8'h00, cy};
  wire [4:0] sub_lo  = {1'b0, acc_r[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cy};
  wire       sub_ov  = (acc_r[7] != opnd[7]) && (sub_dif[7] != acc_r[7]);

  // decimal adjust in two correction steps
  wire       da_fix_lo = (acc_r[3:0] > BCD_MAX_DIGIT) || ac;
  wire [8:0] da_one    = {1'b0, acc_r} + (da_fix_lo ? BCD_FIX_LOW : 9'h000);
  wire       da_fix_hi = (da_one[7:4] > BCD_MAX_DIGIT) || da_one[8] || cy;
  wire [8:0] da_two    = {1'b0, da_one[7:0]} + (da_fix_hi ? BCD_FIX_HIGH : 9'h000);
  wire       da_cy     = cy || da_one[8] || da_two[8];

  // multiply and divide results
  logic [15:0] md_prod;
  logic [7:0]  md_quot, md_rem;
  logic        md_zero;

  csfr_muldiv u_muldiv
  (
    .i_dividend  (acc_r),
    .i_divisor   (sec_r),
    .o_product   (md_prod),
    .o_quotient  (md_quot),
    .o_remainder (md_rem),
    .o_div_zero  (md_zero)
  );

  // operation effects, then special register writes on top
  always_comb
  begin
    acc_nxt = acc_r;
    sec_nxt = sec_r;
    sp_nxt  = sp_r;
    psw_nxt = psw_r;
    if (op_on)
    begin
      unique case (i_op_code)
        OP_ADD, OP_ADDC:
        begin
          acc_nxt           = add_sum[7:0];
          psw_nxt[ST_CARRY] = add_sum[8];
          psw_nxt[ST_HALF]  = add_lo[4];
          psw_nxt[ST_RANGE] = add_ov;
        end
        OP_SUBB:
        begin
          acc_nxt           = sub_dif[7:0];
          psw_nxt[ST_CARRY] = sub_dif[8];
          psw_nxt[ST_HALF]  = sub_lo[4];
          psw_nxt[ST_RANGE] = sub_ov;
        end
        OP_MUL:
        begin
          acc_nxt           = md_prod[7:0];
          sec_nxt           = md_prod[15:8];
          psw_nxt[ST_CARRY] = 1'b0;
          psw_nxt[ST_RANGE] = (md_prod[15:8] != 8'h00);
        end
        OP_DIV:
        begin
          psw_nxt[ST_CARRY] = 1'b0;
          psw_nxt[ST_RANGE] = md_zero;
          // zero divisor leaves both operands as they were
          if (!md_zero)
          begin
            acc_nxt = md_quot;
            sec_nxt = md_rem;
          end
        end
        OP_DA:
        begin
          acc_nxt           = da_two[7:0];
          psw_nxt[ST_CARRY] = da_cy;
        end
        OP_RRC:
        begin
          acc_nxt           = {cy, acc_r[7:1]};
          psw_nxt[ST_CARRY] = acc_r[0];
        end
        OP_RLC:
        begin
          acc_nxt           = {acc_r[6:0], cy};
          psw_nxt[ST_CARRY] = acc_r[7];
        end
        OP_SETB_C: psw_nxt[ST_CARRY] = 1'b1;
        OP_CLR_C:  psw_nxt[ST_CARRY] = 1'b0;
        OP_CPL_C:  psw_nxt[ST_CARRY] = !cy;
        OP_ANL_C:  psw_nxt[ST_CARRY] = cy && i_op_bit;
        OP_ANL_NC: psw_nxt[ST_CARRY] = cy && !i_op_bit;
        OP_ORL_C:  psw_nxt[ST_CARRY] = cy || i_op_bit;
        OP_ORL_NC: psw_nxt[ST_CARRY] = cy || !i_op_bit;
        OP_MOV_C:  psw_nxt[ST_CARRY] = i_op_bit;
        OP_CJNE:   psw_nxt[ST_CARRY] = (acc_r < opnd);
        OP_PUSH:   sp_nxt = sp_r + 8'h01;
        OP_POP:    sp_nxt = sp_r - 8'h01;
        OP_CALL:   sp_nxt = sp_r + 8'h02;
        OP_RET:    sp_nxt = sp_r - 8'h02;
        default:   sp_nxt = sp_r;  // undefined code on the port: no effect
      endcase
    end
    // software writes override the addressed register
    if (wr_acc)
      acc_nxt = i_sfr_wdata;
    if (wr_sec)
      sec_nxt = i_sfr_wdata;
    if (wr_sp)
      sp_nxt  = i_sfr_wdata;
    if (wr_psw)
      psw_nxt = i_sfr_wdata;
    psw_nxt[ST_PARITY] = 1'b0;  // parity is kept in its own flop
  end

  // operand, stack and status registers
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      acc_r <= RST_BYTE;
      sec_r <= RST_BYTE;
      sp_r  <= RST_STACK_TOP;
      psw_r <= RST_BYTE;
      par_r <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      sec_r <= sec_nxt;
      sp_r  <= sp_nxt;
      psw_r <= psw_nxt;
      par_r <= ^acc_nxt;  // follows the value the operand will hold
    end
  end

  // auxiliary control; upper nibble is not implemented
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      aux_r <= RST_AUX_CTRL;
    else if (wr_aux)
      aux_r <= i_sfr_wdata[AUX_WIDTH-1:0];
  end

  // the two pointers share one address pair; only the selected one is written
  for (genvar g = 0; g < 2; g++)
  begin : g_data_pointer_pair
    wire mine = (sel_ptr == 1'(g));
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
      if (!i_nrst)
        data_pointer_pair_r[g] <= RST_DATA_POINTER_PAIR;
      else if (mine && wr_dpl)
        data_pointer_pair_r[g] <= {data_pointer_pair_r[g][15:8], i_sfr_wdata};
      else if (mine && wr_dph)
        data_pointer_pair_r[g] <= {i_sfr_wdata, data_pointer_pair_r[g][7:0]};
    end
  end

  // read multiplexer; unmapped addresses answer zero with no hit
  logic [7:0] rd_mux;
  logic       rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (i_sfr_addr)
      SFR_PRIMARY:   rd_mux = acc_r;
      SFR_SECOND:    rd_mux = sec_r;
      SFR_STACK_TOP: rd_mux = sp_r;
      SFR_DATA_POINTER_PAIR_LOW:  rd_mux = data_pointer_pair_act[7:0];
      SFR_DATA_POINTER_PAIR_HIGH: rd_mux = data_pointer_pair_act[15:8];
      SFR_STATUS:    rd_mux = {psw_r[7:1], par_r};
      SFR_AUX_CTRL:  rd_mux = {4'h0, aux_r};
      default:
      begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // registered read answer
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdata_r <= 8'h00;
      hit_r   <= 1'b0;
    end
    else
    begin
      rdata_r <= i_sfr_rd ? rd_mux : 8'h00;
      hit_r   <= i_sfr_rd && rd_hit;
    end
  end

  // stack memory request decode
  wire is_push = op_on && (i_op_code == OP_PUSH);
  wire is_pop  = op_on && (i_op_code == OP_POP);
  wire is_call = op_on && (i_op_code == OP_CALL);
  wire is_ret  = op_on && (i_op_code == OP_RET);

  // stack requests: writes go above the old top, reads start at the old top
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      stk_we_r    <= 1'b0;
      stk_re_r    <= 1'b0;
      stk_two_r   <= 1'b0;
      stk_addr_r  <= 8'h00;
      stk_wdata_r <= 16'h0000;
    end
    else
    begin
      stk_we_r    <= is_push || is_call;
      stk_re_r    <= is_pop || is_ret;
      stk_two_r   <= is_call || is_ret;
      stk_addr_r  <= (is_push || is_call) ? sp_r + 8'h01 : sp_r;
      stk_wdata_r <= is_call ? i_op_pc : {8'h00, opnd};
    end
  end

  // configuration copy, taken on the first edge after reset release
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cfg_r      <= RST_CFG_WORD;
      cfg_done_r <= 1'b0;
    end
    else if (!cfg_done_r)
    begin
      cfg_r      <= i_cfg_word;
      cfg_done_r <= 1'b1;
    end
  end

  // outputs
  assign o_sfr_rdata     = rdata_r;
  assign o_sfr_hit       = hit_r;
  assign o_stk_we        = stk_we_r;
  assign o_stk_re        = stk_re_r;
  assign o_stk_two       = stk_two_r;
  assign o_stk_addr      = stk_addr_r;
  assign o_stk_wdata     = stk_wdata_r;
  assign o_data_pointer_pair          = data_pointer_pair_act;
  assign o_code_idx_addr = data_pointer_pair_act + {8'h00, acc_r};
  assign o_bank_base     = {6'h00, psw_r[ST_BANK_HI], psw_r[ST_BANK_LO]}
                           << BANK_STRIDE_SH;
  assign o_aux_ctrl      = aux_r[3:1];
  assign o_fetch_region  = region_of(i_fetch_addr);
  assign o_iap_free      = (region_of(i_iap_addr) == RG_IAP_FREE);
  assign o_cfg_word      = cfg_r;
  assign o_cfg_loaded    = cfg_done_r;

endmodule : csfr_core

//--- core/csfr_muldiv.sv
// Purpose: single-cycle 8x8 multiply and 8/8 divide for the operand pair
// Assumes: purely combinational, result taken by the caller in the same cycle
// Notes:   divide is a restoring loop unrolled by synthesis; long path, 8 stages
module csfr_muldiv
  import csfr_pkg::*;
(
  // operands
  input  wire logic [7:0]  i_dividend,   // primary operand
  input  wire logic [7:0]  i_divisor,    // second operand
  // results
  output logic      [15:0] o_product,    // full product
  output logic      [7:0]  o_quotient,   // quotient, meaningless on zero divisor
  output logic      [7:0]  o_remainder,  // remainder, meaningless on zero divisor
  output logic             o_div_zero    // divisor is zero
);

  // unsigned product, operands widened so no bits are lost
  assign o_product  = {8'h00, i_dividend} * {8'h00, i_divisor};
  assign o_div_zero = (i_divisor == 8'h00);

  // restoring division, one quotient bit per step from the top
  always_comb
  begin
    logic [8:0] part;
    part       = 9'h000;
    o_quotient = 8'h00;
    for (int k = 7; k >= 0; k--)
    begin
      part = {part[7:0], i_dividend[k]};
      if (part >= {1'b0, i_divisor})
      begin
        part          = part - {1'b0, i_divisor};
        o_quotient[k] = 1'b1;
      end
    end
    o_remainder = part[7:0];
  end

endmodule : csfr_muldiv

//--- core/csfr_pkg.sv
// Purpose: shared constants and types of the core special register set
// Assumes: 8-bit special register space, 16-bit program addresses
// Notes:   every offset, reset value, field position and map bound lives here
package csfr_pkg;

  // special register addresses
  localparam logic [7:0] SFR_STACK_TOP   = 8'h81;  // stack_top_pointer
  localparam logic [7:0] SFR_DATA_POINTER_PAIR_LOW    = 8'h82;  // data_ptr_low
  localparam logic [7:0] SFR_DATA_POINTER_PAIR_HIGH   = 8'h83;  // data_ptr_high
  localparam logic [7:0] SFR_STATUS      = 8'hD0;  // status_word
  localparam logic [7:0] SFR_PRIMARY     = 8'hE0;  // primary_operand
  localparam logic [7:0] SFR_SECOND      = 8'hF0;  // second_operand
  localparam logic [7:0] SFR_AUX_CTRL    = 8'hF8;  // auxiliary_control_one

  // values after reset
  localparam logic [7:0]  RST_STACK_TOP  = 8'h07;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [15:0] RST_DATA_POINTER_PAIR       = 16'h0000;
  localparam logic [3:0]  RST_AUX_CTRL   = 4'h0;
  localparam logic [15:0] RST_CFG_WORD   = 16'h0000;

  // status word field positions
  localparam int ST_CARRY    = 7;  // carry_bit
  localparam int ST_HALF     = 6;  // half_carry_bit
  localparam int ST_UFLAG0   = 5;  // user_flag_zero
  localparam int ST_BANK_HI  = 4;  // bank_select_high
  localparam int ST_BANK_LO  = 3;  // bank_select_low
  localparam int ST_RANGE    = 2;  // signed_range_bit
  localparam int ST_UFLAG1   = 1;  // user_flag_one
  localparam int ST_PARITY   = 0;  // parity of primary operand

  // auxiliary control field positions
  localparam int AUX_PTR_SEL = 0;  // pointer_choice_bit
  localparam int AUX_WIDTH   = 4;  // bits 3..0 implemented, 7..4 read zero

  // working bank stride in internal memory
  localparam logic [7:0] BANK_STRIDE_SH = 8'h03;  // bank n starts at n*8

  // decimal adjust thresholds and corrections
  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
  localparam logic [8:0] BCD_FIX_LOW   = 9'h006;
  localparam logic [8:0] BCD_FIX_HIGH  = 9'h060;

  // program memory map (16K flash)
  localparam logic [15:0] PM_TOP        = 16'h3FFF;
  localparam logic [15:0] PM_VEC_END    = 16'h005F;
  localparam logic [15:0] PM_ICE_START  = 16'h1D00;
  localparam logic [15:0] PM_ICE_END    = 16'h1FFF;
  localparam logic [15:0] PM_FREE_START = 16'h3F00;
  localparam logic [15:0] PM_FREE_END   = 16'h3FFD;
  localparam logic [15:0] PM_CFG_START  = 16'h3FFE;

  // operations the instruction sequencer hands to this block
  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_ADDC, OP_SUBB, OP_MUL, OP_DIV, OP_DA, OP_RRC, OP_RLC,
    OP_SETB_C, OP_CLR_C, OP_CPL_C, OP_ANL_C, OP_ANL_NC, OP_ORL_C, OP_ORL_NC,
    OP_MOV_C, OP_CJNE, OP_PUSH, OP_POP, OP_CALL, OP_RET
  } csfr_op_e;

  // program memory partitions
  typedef enum logic [2:0] {
    RG_VECTOR, RG_USER, RG_ICE_RESERVE, RG_IAP_FREE, RG_CONFIG, RG_OUTSIDE
  } csfr_region_e;

endpackage : csfr_pkg

//--- sim/csfr_core_asserts.sv
// Purpose: port-level checks of the core special register set
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to csfr_core; watches its ports only
module csfr_core_asserts
  import csfr_pkg::*;
(
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  // register port
  input wire logic [7:0]  i_sfr_addr,
  input wire logic        i_sfr_wr,
  input wire logic        i_sfr_rd,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic        o_sfr_hit,
  // operation port and stack requests
  input wire logic        i_op_valid,
  input csfr_op_e         i_op_code,
  input wire logic [7:0]  i_op_operand,
  input wire logic [15:0] i_op_pc,
  input wire logic        o_stk_we,
  input wire logic        o_stk_re,
  input wire logic        o_stk_two,
  input wire logic [7:0]  o_stk_addr,
  input wire logic [15:0] o_stk_wdata,
  // views, map and configuration
  input wire logic [7:0]  o_bank_base,
  input wire logic [15:0] i_fetch_addr,
  input csfr_region_e     o_fetch_region,
  input wire logic [15:0] i_iap_addr,
  input wire logic        o_iap_free,
  input wire logic [15:0] o_cfg_word,
  input wire logic        o_cfg_loaded
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  // address lands on one of the seven registers here
  wire sfr_mapped = i_sfr_addr inside {8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0, 8'hF8};
  // an operation that cannot be overridden by a stack pointer write
  sequence s_push;
    i_op_valid && i_op_code == OP_PUSH && !i_sfr_wr;
  endsequence
  sequence s_pop;
    i_op_valid && i_op_code == OP_POP && !i_sfr_wr;
  endsequence

  a_read_idle: assert property (!i_sfr_rd |=> o_sfr_rdata == 8'h00 && !o_sfr_hit)
    else $error("read data not idle after a cycle without read");
  a_read_hit: assert property (i_sfr_rd |=> o_sfr_hit == $past(sfr_mapped))
    else $error("read hit does not follow the address map");
  a_bank_base: assert property (o_bank_base[2:0] == 3'h0 && o_bank_base[7:5] == 3'h0)
    else $error("bank base off the eight-byte grid");
  a_push_data: assert property (s_push |=> o_stk_we && !o_stk_two
    && o_stk_wdata == {8'h00, $past(i_op_operand)})
    else $error("push request malformed");
  a_push_step: assert property (s_push ##1 s_push |=> o_stk_addr == $past(o_stk_addr) + 8'h01)
    else $error("push pair did not advance by one");
  a_pop_step: assert property (s_pop ##1 s_pop |=> o_stk_re && o_stk_addr == $past(o_stk_addr) - 8'h01)
    else $error("pop pair did not retreat by one");
  a_call_word: assert property (i_op_valid && i_op_code == OP_CALL
    |=> o_stk_we && o_stk_two && o_stk_wdata == $past(i_op_pc))
    else $error("call did not store the return address");
  a_iap_free: assert property (o_iap_free == (i_iap_addr >= 16'h3F00 && i_iap_addr <= 16'h3FFD))
    else $error("free area flag wrong");
  a_vector_zone: assert property (i_fetch_addr <= 16'h005F |-> o_fetch_region == RG_VECTOR)
    else $error("vector area misclassified");
  a_cfg_hold: assert property (o_cfg_loaded |=> o_cfg_loaded && $stable(o_cfg_word))
    else $error("configuration copy changed after capture");
endmodule : csfr_core_asserts

bind csfr_core csfr_core_asserts csfr_core_asserts_inst (.i_sys_clk, .i_nrst, .i_sfr_addr,
  .i_sfr_wr, .i_sfr_rd, .o_sfr_rdata, .o_sfr_hit, .i_op_valid, .i_op_code, .i_op_operand,
  .i_op_pc, .o_stk_we, .o_stk_re, .o_stk_two, .o_stk_addr, .o_stk_wdata, .o_bank_base,
  .i_fetch_addr, .o_fetch_region, .i_iap_addr, .o_iap_free, .o_cfg_word, .o_cfg_loaded);

//--- sim/tb_top.sv
// Purpose: self-checking bench for the core special register set
// Assumes: 25 MHz clock, inputs driven 1 ns after each rising edge
// Notes:   expected values are worked out by hand from the register map
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %0t got %h expected %h", $time, g, e); end end
module tb_top
  import csfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus, all given at time zero
  logic         i_sys_clk = 1'b0, i_nrst = 1'b0, i_op_bit = 1'b0;
  logic         i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_op_valid = 1'b0;
  logic [7:0]   i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_op_operand = 8'h00;
  csfr_op_e     i_op_code = OP_NONE;
  logic [15:0]  i_op_pc = 16'h0000, i_fetch_addr = 16'h0000, i_iap_addr = 16'h0000;
  logic [15:0]  i_cfg_word = 16'hA55A;
  // observed outputs
  logic [7:0]   o_sfr_rdata, o_stk_addr, o_bank_base;
  logic         o_sfr_hit, o_stk_we, o_stk_re, o_stk_two, o_iap_free, o_cfg_loaded;
  logic [15:0]  o_stk_wdata, o_data_pointer_pair, o_code_idx_addr, o_cfg_word;
  logic [2:0]   o_aux_ctrl;
  csfr_region_e o_fetch_region;
  int           fail_count = 0, cmp_count = 0;

  csfr_core csfr_core_inst (.i_sys_clk, .i_nrst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata,
    .o_sfr_rdata, .o_sfr_hit, .i_op_valid, .i_op_code, .i_op_operand, .i_op_bit, .i_op_pc,
    .o_stk_we, .o_stk_re, .o_stk_two, .o_stk_addr, .o_stk_wdata, .o_data_pointer_pair, .o_code_idx_addr,
    .o_bank_base, .o_aux_ctrl, .i_fetch_addr, .i_iap_addr, .o_fetch_region, .o_iap_free,
    .i_cfg_word, .o_cfg_word, .o_cfg_loaded);

  // free-running core clock
  always #20 i_sys_clk = ~i_sys_clk;

  // one cycle of stimulus; every strobe set once so back-to-back cycles never double-drive
  task automatic bus(input logic w, input logic r, input logic v, input logic [7:0] a,
                     input logic [7:0] d);
    i_sfr_wr = w;
    i_sfr_rd = r;
    i_op_valid = v;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_op_operand = d;
    @(posedge i_sys_clk);
    #1;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, 1'b0, a, d);
  endtask : wr
  // read answer is registered, so it is judged just after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    bus(1'b0, 1'b1, 1'b0, a, 8'h00);
    `CHK(o_sfr_rdata, e)
    `CHK(o_sfr_hit, h)
  endtask : rd
  task automatic op(input csfr_op_e c, input logic [7:0] d);
    i_op_code = c;
    bus(1'b0, 1'b0, 1'b1, 8'h00, d);
  endtask : op
  // stack request flags {we, re, two} and first address
  task automatic stk(input logic [2:0] f, input logic [7:0] a);
    `CHK({o_stk_we, o_stk_re, o_stk_two}, f)
    `CHK(o_stk_addr, a)
  endtask : stk

  task automatic t_reset;
    `CHK({o_cfg_loaded, o_cfg_word}, {1'b1, 16'hA55A})
    i_cfg_word = 16'h1234;
    rd(8'h81, 8'h07, 1'b1);
    rd(8'hE0, 8'h00, 1'b1);
    rd(8'hF0, 8'h00, 1'b1);
    rd(8'h82, 8'h00, 1'b1);
    rd(8'h83, 8'h00, 1'b1);
    rd(8'hD0, 8'h00, 1'b1);
    rd(8'hF8, 8'h00, 1'b1);
    bus(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    `CHK({o_sfr_hit, o_sfr_rdata, o_cfg_word}, {1'b0, 8'h00, 16'hA55A})
  endtask : t_reset

  task automatic t_regs;
    wr(8'hE0, 8'h5B);
    rd(8'hE0, 8'h5B, 1'b1);
    rd(8'hD0, 8'h01, 1'b1);
    wr(8'hF0, 8'hC3);
    rd(8'hF0, 8'hC3, 1'b1);
    // parity bit is not writable, so a written 0 still reads back as odd parity
    wr(8'hD0, 8'hFE);
    rd(8'hD0, 8'hFF, 1'b1);
    for (int b = 0; b < 4; b++)
    begin
      wr(8'hD0, 8'(b * 8));
      `CHK(o_bank_base, 8'(b * 8))
    end
    wr(8'hF8, 8'hFF);
    rd(8'hF8, 8'h0F, 1'b1);
    `CHK(o_aux_ctrl, 3'h7)
    wr(8'hF8, 8'h00);
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    `CHK(o_data_pointer_pair, 16'h1234)
    wr(8'hF8, 8'h01);
    `CHK(o_data_pointer_pair, 16'h0000)
    wr(8'h82, 8'hCD);
    wr(8'h83, 8'hAB);
    rd(8'h83, 8'hAB, 1'b1);
    wr(8'hF8, 8'h00);
    rd(8'h82, 8'h34, 1'b1);
    `CHK(o_code_idx_addr, 16'h128F)
    wr(8'h90, 8'h77);
    rd(8'h90, 8'h00, 1'b0);
  endtask : t_regs

  task automatic t_stack;
    wr(8'h81, 8'h07);
    op(OP_PUSH, 8'hAA);
    stk(3'b100, 8'h08);
    `CHK(o_stk_wdata, 16'h00AA)
    op(OP_PUSH, 8'h55);
    stk(3'b100, 8'h09);
    op(OP_POP, 8'h00);
    stk(3'b010, 8'h09);
    op(OP_POP, 8'h00);
    stk(3'b010, 8'h08);
    rd(8'h81, 8'h07, 1'b1);
    `CHK({o_stk_we, o_stk_re}, 2'b00)
    i_op_pc = 16'h1234;
    op(OP_CALL, 8'h00);
    stk(3'b101, 8'h08);
    `CHK(o_stk_wdata, 16'h1234)
    rd(8'h81, 8'h09, 1'b1);
    op(OP_RET, 8'h00);
    stk(3'b011, 8'h09);
    rd(8'h81, 8'h07, 1'b1);
  endtask : t_stack

  task automatic t_alu;
    wr(8'hD0, 8'h00);
    wr(8'hE0, 8'hFF);
    op(OP_ADD, 8'h01);
    rd(8'hD0, 8'hC0, 1'b1);
    rd(8'hE0, 8'h00, 1'b1);
    op(OP_CLR_C, 8'h00);
    rd(8'hD0, 8'h40, 1'b1);
    op(OP_SETB_C, 8'h00);
    rd(8'hD0, 8'hC0, 1'b1);
    wr(8'hE0, 8'h10);
    wr(8'hF0, 8'h20);
    op(OP_MUL, 8'h00);
    rd(8'hD0, 8'h44, 1'b1);
    rd(8'hF0, 8'h02, 1'b1);
    wr(8'hE0, 8'h17);
    wr(8'hF0, 8'h05);
    op(OP_SETB_C, 8'h00);
    op(OP_DIV, 8'h00);
    rd(8'hD0, 8'h41, 1'b1);
    rd(8'hE0, 8'h04, 1'b1);
    rd(8'hF0, 8'h03, 1'b1);
    wr(8'hF0, 8'h00);
    op(OP_DIV, 8'h00);
    rd(8'hD0, 8'h45, 1'b1);
  endtask : t_alu

  // carry-only codes, then rotates, carry arithmetic, signed range, decimal adjust, compare
  task automatic t_bits;
    wr(8'hD0, 8'h00);
    op(OP_CPL_C, 8'h00);
    rd(8'hD0, 8'h81, 1'b1);
    op(OP_ANL_C, 8'h00);
    rd(8'hD0, 8'h01, 1'b1);
    op(OP_ORL_NC, 8'h00);
    rd(8'hD0, 8'h81, 1'b1);
    i_op_bit = 1'b1;
    op(OP_ANL_NC, 8'h00);
    rd(8'hD0, 8'h01, 1'b1);
    op(OP_ORL_C, 8'h00);
    rd(8'hD0, 8'h81, 1'b1);
    i_op_bit = 1'b0;
    op(OP_MOV_C, 8'h00);
    rd(8'hD0, 8'h01, 1'b1);
    wr(8'hE0, 8'h81);
    op(OP_RRC, 8'h00);
    rd(8'hE0, 8'h40, 1'b1);
    rd(8'hD0, 8'h81, 1'b1);
    op(OP_RLC, 8'h00);
    rd(8'hE0, 8'h81, 1'b1);
    rd(8'hD0, 8'h00, 1'b1);
    op(OP_SETB_C, 8'h00);
    op(OP_ADDC, 8'h7E);
    rd(8'hD0, 8'hC0, 1'b1);
    op(OP_SUBB, 8'h01);
    rd(8'hE0, 8'hFE, 1'b1);
    rd(8'hD0, 8'hC1, 1'b1);
    wr(8'hE0, 8'h7F);
    op(OP_ADD, 8'h01);
    rd(8'hD0, 8'h45, 1'b1);
    wr(8'hD0, 8'h00);
    wr(8'hE0, 8'h9A);
    op(OP_DA, 8'h00);
    rd(8'hE0, 8'h00, 1'b1);
    rd(8'hD0, 8'h80, 1'b1);
    op(OP_CJNE, 8'h00);
    rd(8'hD0, 8'h00, 1'b1);
  endtask : t_bits

  // partition edges, each address probed on both map outputs
  task automatic t_map;
    logic [15:0]  ma [13] = '{16'h0000, 16'h005F, 16'h0060, 16'h1CFF, 16'h1D00, 16'h1FFF,
      16'h2000, 16'h3EFF, 16'h3F00, 16'h3FFD, 16'h3FFE, 16'h3FFF, 16'h4000};
    csfr_region_e mr [13] = '{RG_VECTOR, RG_VECTOR, RG_USER, RG_USER, RG_ICE_RESERVE,
      RG_ICE_RESERVE, RG_USER, RG_USER, RG_IAP_FREE, RG_IAP_FREE, RG_CONFIG, RG_CONFIG,
      RG_OUTSIDE};
    for (int i = 0; i < 13; i++)
    begin
      i_fetch_addr = ma[i];
      i_iap_addr = ma[i];
      // hold each address across an edge so the checker sees it too
      @(posedge i_sys_clk);
      #1;
      `CHK(o_fetch_region, mr[i])
      `CHK(o_iap_free, (ma[i] >= 16'h3F00 && ma[i] <= 16'h3FFD))
    end
  endtask : t_map

  task finish_test;
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // main sequence: reset for eight cycles, then every scenario in turn
  initial
  begin
    repeat (8) @(posedge i_sys_clk);
    #1 i_nrst = 1'b1;
    @(posedge i_sys_clk);
    #1;
    t_reset();
    t_regs();
    t_stack();
    t_alu();
    t_bits();
    t_map();
    finish_test();
  end

  // the whole run needs about 125 cycles; this cuts a hang short
  initial
  begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule : tb_top
